// File: hw/nvac_top.sv
// Purpose: Byte access control for a 64-location nonvolatile array
// Assumes: Classic Wishbone slave, byte lane 0 only, one clock
// Notes:   A stall holds ack off, which is how the CPU is halted
// How it works
// [RQ1] Control bits 7..2 read as zero and ignore writes.
// [RQ2] Software loads location and byte before setting the write strobe.
// [RQ3] The write strobe clears itself when the programming time ends.
// [RQ4] Software waits for the write strobe to read zero before writing.
// [RQ5] Setting the write strobe stalls the CPU for two cycles.
// [RQ6] Software sets the location first, then the read strobe.
// [RQ7] The read strobe clears with the fetched byte in the byte register.
// [RQ8] A read finishes within the strobing access, no polling needed.
// [RQ9] Setting the read strobe stalls the CPU for four cycles.
// [RQ10] Location and byte registers are not guarded against nesting.
// [RQ11] Software keeps interrupts off while starting a write.
// [RQ12] The 6-bit location selects one of 64 bytes linearly.
// [RQ13] The byte register holds write data, or read data after a read.
// [RQ14] The write strobe reads one for the whole programming time.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "nvac_map.svh"

module nvac_top
    import nvac_pkg::*;
#(
    parameter int PROG_CYC = `NVAC_PROG_CYC
)(
    input  wire logic        i_mclk,
    input  wire logic        i_srst,
    input  wire logic        i_ce,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [9:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_wb_err,
    output logic             o_nvm_busy
);

    localparam logic [7:0] CTRL_IDX = `NVAC_CTRL_IDX;
    localparam logic [7:0] BYTE_IDX = `NVAC_BYTE_IDX;
    localparam logic [7:0] LOC_IDX  = `NVAC_LOC_IDX;
    localparam logic [2:0] WR_STALL = 3'(`NVAC_WR_STALL);
    localparam logic [2:0] RD_STALL = 3'(`NVAC_RD_STALL);
    localparam logic [31:0] PROG_LAST = 32'(PROG_CYC - 1);

    function automatic logic is_reg(input logic [7:0] idx);
        is_reg = (idx == CTRL_IDX) || (idx == BYTE_IDX) || (idx == LOC_IDX);
    endfunction : is_reg

    nvac_req_s   req;
    nvac_bus_e   bus_st;
    logic [7:0]  mem [0:63];
    logic [5:0]  nvm_location_reg;
    logic [7:0]  nvm_byte_reg;
    logic        nvm_write_strobe;
    logic        nvm_read_strobe;
    logic [2:0]  stall_cnt;
    logic [31:0] prog_cnt;
    logic        take;
    logic        hit;
    logic        set_wr;
    logic        set_rd;

    assign req  = '{adr: i_wb_adr[9:2], we: i_wb_we, sel: i_wb_sel[0],
                    dat: i_wb_dat[7:0]};
    assign take = i_ce && i_wb_cyc && i_wb_stb && (bus_st == NVAC_IDLE);
    assign hit  = is_reg(req.adr);
    // A strobe already running ignores a second set
    assign set_wr = take && req.we && req.sel && (req.adr == CTRL_IDX)
                    && req.dat[`NVAC_WR_BIT] && !nvm_write_strobe;
    assign set_rd = take && req.we && req.sel && (req.adr == CTRL_IDX)
                    && req.dat[`NVAC_RD_BIT] && !set_wr;
    assign o_nvm_busy = nvm_write_strobe;

    // Bus handshake: ack is held back while the CPU is stalled
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            bus_st    <= NVAC_IDLE;
            stall_cnt <= 3'h0;
            o_wb_ack  <= 1'b0;
            o_wb_err  <= 1'b0;
        end
        else if (i_ce)
        begin
            o_wb_ack <= 1'b0;
            o_wb_err <= 1'b0;
            case (bus_st)
                NVAC_IDLE:
                begin
                    if (take && (set_wr || set_rd))
                    begin
                        stall_cnt <= set_wr ? WR_STALL : RD_STALL; // RQ5 RQ9
                        bus_st    <= NVAC_STALL;
                    end
                    else if (take)
                    begin
                        o_wb_ack <= hit;
                        o_wb_err <= !hit;
                        bus_st   <= NVAC_ACK;
                    end
                end
                NVAC_STALL:
                begin
                    stall_cnt <= stall_cnt - 3'h1;
                    if (stall_cnt == 3'h1)
                    begin
                        o_wb_ack <= 1'b1;
                        bus_st   <= NVAC_ACK;
                    end
                end
                NVAC_ACK:
                    bus_st <= NVAC_IDLE;
                default:
                    bus_st <= NVAC_IDLE;
            endcase
        end
    end

    // Location and byte registers; no guard against nested use
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            nvm_location_reg <= `NVAC_LOC_RST;
            nvm_byte_reg     <= `NVAC_BYTE_RST;
        end
        else if (i_ce)
        begin
            if (take && req.we && req.sel && req.adr == LOC_IDX)
                nvm_location_reg <= req.dat[5:0]; // RQ10 RQ12
            if (take && req.we && req.sel && req.adr == BYTE_IDX)
                nvm_byte_reg <= req.dat; // RQ13
            else if (nvm_read_strobe)
                nvm_byte_reg <= mem[nvm_location_reg]; // RQ7 RQ13
        end
    end

    // Read strobe: set by the access, cleared with the byte landed
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            nvm_read_strobe <= 1'b0;
        else if (i_ce)
            nvm_read_strobe <= set_rd; // RQ7 RQ8
    end

    // Self-timed write; the array is written once, at the start
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            nvm_write_strobe <= 1'b0;
            prog_cnt         <= 32'h0000_0000;
        end
        else if (i_ce)
        begin
            if (set_wr)
            begin
                nvm_write_strobe <= 1'b1; // RQ14
                prog_cnt         <= 32'h0000_0000;
            end
            else if (nvm_write_strobe)
            begin
                prog_cnt <= prog_cnt + 32'h0000_0001;
                if (prog_cnt == PROG_LAST)
                    nvm_write_strobe <= 1'b0; // RQ3
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_ce && set_wr)
            mem[nvm_location_reg] <= nvm_byte_reg; // RQ12
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            o_wb_dat <= 32'h0000_0000;
        else if (i_ce && take && !req.we)
        begin
            o_wb_dat <= 32'h0000_0000;
            case (req.adr)
                CTRL_IDX: o_wb_dat[1:0] <= {nvm_write_strobe,
                                            nvm_read_strobe}; // RQ1
                BYTE_IDX: o_wb_dat[7:0] <= nvm_byte_reg;
                LOC_IDX:  o_wb_dat[5:0] <= nvm_location_reg;
                default:  o_wb_dat <= 32'h0000_0000;
            endcase
        end
    end

    sequence s_wr_set;
        set_wr;
    endsequence

    sequence s_rd_set;
        set_rd;
    endsequence

    // Stall counts hold only while i_ce runs; a frozen stall is not timed
    sequence s_wr_stall;
        s_wr_set ##0 i_ce[*3];
    endsequence

    sequence s_rd_stall;
        s_rd_set ##0 i_ce[*5];
    endsequence

    a_wr_stall_len: assert property ( // RQ5
        @(posedge i_mclk) disable iff (i_srst)
        s_wr_stall |-> !o_wb_ack && !$past(o_wb_ack) ##1 o_wb_ack)
        else $error("write stall length wrong");

    a_rd_stall_len: assert property ( // RQ9
        @(posedge i_mclk) disable iff (i_srst)
        s_rd_stall |-> !o_wb_ack && !$past(o_wb_ack) && !$past(o_wb_ack, 2)
            && !$past(o_wb_ack, 3) ##1 o_wb_ack)
        else $error("read stall length wrong");

    a_rd_done_fast: assert property ( // RQ8
        @(posedge i_mclk) disable iff (i_srst)
        s_rd_set ##1 i_ce |-> nvm_read_strobe ##1 !nvm_read_strobe)
        else $error("read strobe not cleared");

    a_rd_byte_load: assert property ( // RQ7
        @(posedge i_mclk) disable iff (i_srst)
        nvm_read_strobe && i_ce && !(take && req.we)
        |=> nvm_byte_reg == mem[$past(nvm_location_reg)])
        else $error("read byte not loaded");

    a_wr_busy_hold: assert property ( // RQ14
        @(posedge i_mclk) disable iff (i_srst)
        s_wr_set |=> nvm_write_strobe)
        else $error("write strobe not set");

    a_wr_busy_end: assert property ( // RQ3
        @(posedge i_mclk) disable iff (i_srst)
        nvm_write_strobe && i_ce && !set_wr && prog_cnt == PROG_LAST
        |=> !nvm_write_strobe)
        else $error("write strobe not cleared");

    // Writes leave the last read data standing, so only reads are checked
    a_ctrl_rsvd_zero: assert property ( // RQ1
        @(posedge i_mclk) disable iff (i_srst)
        o_wb_ack && !$past(req.we) && $past(req.adr) == CTRL_IDX
        |-> o_wb_dat[31:2] == '0)
        else $error("reserved bits not zero");

    a_loc_write_ok: assert property ( // RQ12
        @(posedge i_mclk) disable iff (i_srst)
        take && req.we && req.sel && req.adr == LOC_IDX
        |=> nvm_location_reg == $past(req.dat[5:0]))
        else $error("location not stored");

endmodule : nvac_top

// File: hw/nvac_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 40 MHz system clock, Wishbone byte addresses
// Notes:   Offsets are word indices; byte address is four times them
`ifndef NVAC_MAP_SVH
`define NVAC_MAP_SVH

`define NVAC_CTRL_IDX        8'h1C
`define NVAC_BYTE_IDX        8'h1D
`define NVAC_LOC_IDX         8'h1E
`define NVAC_CTRL_RST        8'h00
`define NVAC_BYTE_RST        8'h00
`define NVAC_LOC_RST         6'h00
`define NVAC_RD_BIT          0
`define NVAC_WR_BIT          1
`define NVAC_CLK_HZ          40000000
`define NVAC_PROG_US         2500
`define NVAC_PROG_CYC        ((`NVAC_PROG_US * (`NVAC_CLK_HZ / 1000)) / 1000)
`define NVAC_WR_STALL        2
`define NVAC_RD_STALL        4

`endif

// File: hw/nvac_pkg.sv
// Purpose: Types shared by the access-control block
// Assumes: Constants live in nvac_map.svh
// Notes:   Bus request travels as one packed struct
package nvac_pkg;

    typedef enum logic [1:0] {
        NVAC_IDLE,
        NVAC_STALL,
        NVAC_ACK
    } nvac_bus_e;

    typedef struct packed {
        logic [7:0] adr;
        logic       we;
        logic       sel;
        logic [7:0] dat;
    } nvac_req_s;

endpackage : nvac_pkg

// File: tb/nvac_cpu_model.sv
// Purpose: CPU side doing single I/O register accesses
// Assumes: Classic Wishbone, one access at a time
// Notes:   Released data lines show the inverted last value
`timescale 1ns/1ps
module nvac_cpu_model (
    input  wire logic        i_mclk,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic        i_wb_ack,
    input  wire logic        i_wb_err,
    output logic             o_wb_cyc,
    output logic             o_wb_stb,
    output logic             o_wb_we,
    output logic [3:0]       o_wb_sel,
    output logic [9:0]       o_wb_adr,
    output logic [31:0]      o_wb_dat
);
    initial
    begin
        o_wb_cyc = 1'b0;
        o_wb_stb = 1'b0;
        o_wb_we  = 1'b0;
        o_wb_sel = 4'h0;
        o_wb_adr = 10'h000;
        o_wb_dat = 32'h0000_0000;
    end

    // Caller sets location and byte before a strobe and polls busy
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic e, output int n);
        @(posedge i_mclk);
        o_wb_cyc <= 1'b1;
        o_wb_stb <= 1'b1;
        o_wb_we  <= w;
        o_wb_sel <= 4'h1;
        o_wb_adr <= {idx, 2'b00};
        o_wb_dat <= wd;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            n++;
        end
        while (!(i_wb_ack || i_wb_err) && n < 200);
        rd = i_wb_dat;
        e  = i_wb_err;
        o_wb_cyc <= 1'b0;
        o_wb_stb <= 1'b0;
        o_wb_dat <= ~wd;
    endtask : bus
endmodule : nvac_cpu_model

// File: tb/eeprom_access_control_test.sv
// Purpose: Self-checking bench for the access-control block
// Assumes: Short programming time via PROG_CYC
// Notes:   Array model is an array of bytes indexed by location
`timescale 1ns/1ps
`include "nvac_map.svh"
module eeprom_access_control_test;
    localparam int PROG = 30;
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic i_ce   = 1'b1;
    logic cyc, stb, we, ack, err, busy;
    logic [3:0]  sel;
    logic [9:0]  adr;
    logic [31:0] wdat, rdat;
    logic [31:0] seed = 32'ha4fc_93f0;
    logic [7:0]  mem [64];
    logic        busy_q = 1'b0;
    int          busy_len = 0;
    int          last_len = 0;
    int          err_total = 0;
    int          num_checks = 0;

    always #12.5 i_mclk = ~i_mclk;

    // Length of each busy period, captured when it ends
    always @(posedge i_mclk)
    begin
        busy_q <= busy;
        busy_len <= busy ? busy_len + 1 : 0;
        if (busy_q && !busy)
            last_len <= busy_len;
    end

    nvac_top #(.PROG_CYC(PROG)) u_nvac_top (.i_mclk(i_mclk),
        .i_srst(i_srst), .i_ce(i_ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_sel(sel), .i_wb_adr(adr), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
        .o_nvm_busy(busy));
    nvac_cpu_model u_nvac_cpu_model (.i_mclk(i_mclk), .i_wb_dat(rdat),
        .i_wb_ack(ack), .i_wb_err(err), .o_wb_cyc(cyc), .o_wb_stb(stb),
        .o_wb_we(we), .o_wb_sel(sel), .o_wb_adr(adr), .o_wb_dat(wdat));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    // Upper data bits are random; only the low byte may matter
    task automatic acc(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic e, output int n);
        logic [31:0] r;
        r = rnd();
        r[7:0] = d;
        u_nvac_cpu_model.bus(w, idx, r, rd, e, n);
        if (n >= 200)
        begin
            err_total++;
            report_and_stop();
        end
    endtask : acc

    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input int lat);
        logic [31:0] rd;
        logic e;
        int n;
        acc(1'b1, idx, d, rd, e, n);
        chk("ack latency", 32'(lat), 32'(n));
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        logic e;
        int n;
        acc(1'b0, idx, 8'h00, rd, e, n);
        chk("read data", {24'h00_0000, exp}, rd);
    endtask : rdc

    initial
    begin
        logic [31:0] r, rd;
        logic e;
        int n;
        logic [5:0] loc;
        logic [7:0] b;
        logic [7:0] cw;
        int         k;
        int         plen;
        repeat (2) @(posedge i_mclk);
        i_srst <= 1'b0;
        rdc(`NVAC_CTRL_IDX, `NVAC_CTRL_RST);
        rdc(`NVAC_BYTE_IDX, `NVAC_BYTE_RST);
        rdc(`NVAC_LOC_IDX, {2'b00, `NVAC_LOC_RST});
        acc(1'b0, 8'h3F, 8'h00, rd, e, n);
        chk("unmapped err", 32'h1, {31'h0, e});
        for (int i = 0; i < 5; i++)
        begin
            r = rnd();
            loc = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : r[5:0];
            b = r[15:8];
            wr(`NVAC_LOC_IDX, {r[23:22], loc}, 2);
            wr(`NVAC_BYTE_IDX, b, 2);
            cw = {r[31:26], 1'b1, r[24]};
            wr(`NVAC_CTRL_IDX, cw, `NVAC_WR_STALL + 2);
            mem[loc] = b;
            plen = PROG;
            // Bus is idle here, so a frozen block cannot hold ack high
            if (i == 2)
            begin
                i_ce <= 1'b0;
                repeat (7) @(posedge i_mclk);
                i_ce <= 1'b1;
                plen = PROG + 7;
            end
            rdc(`NVAC_CTRL_IDX, 8'h02);
            chk("busy level", 32'h1, {31'h0, busy});
            wr(`NVAC_CTRL_IDX, 8'h02, 2);
            wr(`NVAC_LOC_IDX, {2'b00, loc ^ 6'h01}, 2);
            wr(`NVAC_BYTE_IDX, ~b, 2);
            k = 0;
            do
            begin
                acc(1'b0, `NVAC_CTRL_IDX, 8'h00, rd, e, n);
                k++;
            end
            while (rd[1] !== 1'b0 && k < 100);
            chk("strobe cleared", 32'h0, rd);
            chk("programming length", 32'(plen), 32'(last_len));
            rdc(`NVAC_BYTE_IDX, ~b);
            wr(`NVAC_LOC_IDX, {2'b00, loc}, 2);
            cw = {r[21:16], 2'b01};
            wr(`NVAC_CTRL_IDX, cw, `NVAC_RD_STALL + 2);
            rdc(`NVAC_CTRL_IDX, 8'h00);
            rdc(`NVAC_BYTE_IDX, mem[loc]);
        end
        // Reset in mid-programming: registers clear, the array keeps its byte
        wr(`NVAC_LOC_IDX, 8'h15, 2);
        wr(`NVAC_BYTE_IDX, 8'h5A, 2);
        wr(`NVAC_CTRL_IDX, 8'h02, `NVAC_WR_STALL + 2);
        mem[6'h15] = 8'h5A;
        i_srst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_srst <= 1'b0;
        chk("busy after reset", 32'h0, {31'h0, busy});
        rdc(`NVAC_CTRL_IDX, `NVAC_CTRL_RST);
        rdc(`NVAC_BYTE_IDX, `NVAC_BYTE_RST);
        rdc(`NVAC_LOC_IDX, {2'b00, `NVAC_LOC_RST});
        wr(`NVAC_LOC_IDX, 8'h15, 2);
        wr(`NVAC_CTRL_IDX, 8'h01, `NVAC_RD_STALL + 2);
        rdc(`NVAC_BYTE_IDX, mem[6'h15]);
        report_and_stop();
    end
endmodule : eeprom_access_control_test
